// >>> drc_dev.sv
`timescale 1ns/1ps
`include "drc_params.svh"

module drc_dev (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic rst_n_i,
  // Link
  drc_if.dev link,
  // Display scan port
  input wire logic [9:0] scan_addr_i,
  output logic [7:0] scan_data_o,
  // Settings
  output logic [5:0] start_line_o,
  output logic [7:0] contrast_o,
  output logic seg_remap_o,
  output logic entire_on_o,
  output drc_pkg::drc_amode_t addr_mode_o,
  output logic [6:0] col_ptr_o,
  output logic [2:0] page_ptr_o
);
  import drc_pkg::*;

  drc_dev_st_t q, d;
  logic [7:0] display_ram [0:`DRC_RAM_WORDS-1];
  logic [6:0] phys_col;
  logic [9:0] ram_addr;
  logic byte_ok;
  logic byte_dc;
  logic [7:0] byte_v;
  logic rd_end;
  logic rd_act;
  logic advance;
  logic wr_en;
  logic cs_on;

  always_comb begin
    d = q;
    byte_ok = 1'b0;
    byte_dc = 1'b0;
    byte_v = 8'h00;
    rd_end = 1'b0;
    rd_act = 1'b0;
    advance = 1'b0;
    wr_en = 1'b0;
    // Later data lands on mirrored columns; stored bytes stay put
    phys_col = q.remap ? ~q.col : q.col;
    ram_addr = {q.page, phys_col};
    cs_on = !q.cs_s[1];

    // Pin synchronisers
    d.mode_s1 = link.bus_mode;
    d.mode_s2 = q.mode_s1;
    d.cs_s = {q.cs_s[1:0], link.cs_n};
    d.dc_s = {q.dc_s[1:0], link.dc};
    d.rw_s = {q.rw_s[1:0], link.rw_wr_n};
    d.e_s = {q.e_s[1:0], link.e_rd_n};
    d.sclk_s = {q.sclk_s[1:0], link.sclk};
    d.sdin_s = {q.sdin_s[1:0], link.sdin};
    d.d_s1 = link.bus_d;
    d.d_s2 = q.d_s1;

    // Transfer decode per bus style
    unique case (drc_bus_t'(q.mode_s2))
      DRC_BUS_6800: begin
        rd_act = cs_on & q.e_s[1] & q.rw_s[1];
        if (cs_on && q.e_s[2] && !q.e_s[1]) begin
          if (q.rw_s[1]) begin
            rd_end = 1'b1;
          end else begin
            byte_ok = 1'b1;
            byte_dc = q.dc_s[1];
            byte_v = q.d_s2;
          end
        end
      end
      DRC_BUS_8080: begin
        rd_act = cs_on & !q.e_s[1];
        if (cs_on && !q.rw_s[2] && q.rw_s[1]) begin
          byte_ok = 1'b1;
          byte_dc = q.dc_s[1];
          byte_v = q.d_s2;
        end
        if (cs_on && !q.e_s[2] && q.e_s[1]) begin
          rd_end = 1'b1;
        end
      end
      DRC_BUS_SERIAL: begin
        // No read path and no data drive in this style
        if (!cs_on) begin
          d.bit_cnt = 3'h0;
        end else if (!q.sclk_s[2] && q.sclk_s[1]) begin
          d.shift = {q.shift[6:0], q.sdin_s[1]};
          d.bit_cnt = q.bit_cnt + 3'h1;
          if (q.bit_cnt == 3'h7) begin
            byte_ok = 1'b1;
            byte_dc = q.dc_s[1];
            byte_v = {q.shift[6:0], q.sdin_s[1]};
          end
        end
      end
      default: ;
    endcase

    // Read drive: data path gives the prefetched byte, command path gives status
    d.dout_oe_n = !rd_act;
    d.dout = q.dc_s[1] ? q.rd_latch : `DRC_STATUS_BYTE;
    if (rd_end && q.dc_s[1]) begin
      // Returned byte was fetched on the previous read, so the first is a dummy
      d.rd_latch = display_ram[ram_addr];
      advance = 1'b1;
    end
    if (byte_ok && byte_dc) begin
      wr_en = 1'b1;
      advance = 1'b1;
    end

    // Command interpreter
    if (byte_ok && !byte_dc) begin
      unique case (q.arg)
        DRC_ARG_NONE: begin
          if (byte_v[7:4] == `DRC_CMD_COL_LO) begin
            d.col[3:0] = byte_v[3:0];
          end else if (byte_v[7:3] == `DRC_CMD_COL_HI) begin
            d.col[6:4] = byte_v[2:0];
          end else if (byte_v == `DRC_CMD_AMODE) begin
            d.arg = DRC_ARG_AMODE;
          end else if (byte_v == `DRC_CMD_COL_RANGE) begin
            d.arg = DRC_ARG_COL_S;
          end else if (byte_v == `DRC_CMD_PAGE_RANGE) begin
            d.arg = DRC_ARG_PG_S;
          end else if (byte_v == `DRC_CMD_CONTRAST) begin
            d.arg = DRC_ARG_CONTRAST;
          end else if (byte_v[7:6] == `DRC_CMD_START_LINE) begin
            d.start_line = byte_v[5:0];
          end else if (byte_v[7:1] == `DRC_CMD_REMAP) begin
            d.remap = byte_v[0];
          end else if (byte_v[7:1] == `DRC_CMD_ENTIRE_ON) begin
            d.entire_on = byte_v[0];
          end else if (byte_v[7:3] == `DRC_CMD_PAGE_SEL) begin
            d.page = byte_v[2:0];
          end
        end
        DRC_ARG_AMODE: begin
          // Upper field bit set means page mode, low bit ignored
          d.amode = byte_v[1] ? DRC_AM_PAGE : (byte_v[0] ? DRC_AM_VERT : DRC_AM_HORIZ);
          d.arg = DRC_ARG_NONE;
        end
        DRC_ARG_COL_S: begin
          d.col_start = byte_v[6:0];
          d.col = byte_v[6:0];
          d.arg = DRC_ARG_COL_E;
        end
        DRC_ARG_COL_E: begin
          d.col_end = byte_v[6:0];
          d.arg = DRC_ARG_NONE;
        end
        DRC_ARG_PG_S: begin
          d.page_start = byte_v[2:0];
          d.page = byte_v[2:0];
          d.arg = DRC_ARG_PG_E;
        end
        DRC_ARG_PG_E: begin
          d.page_end = byte_v[2:0];
          d.arg = DRC_ARG_NONE;
        end
        DRC_ARG_CONTRAST: begin
          d.contrast = byte_v;
          d.arg = DRC_ARG_NONE;
        end
        default: d.arg = DRC_ARG_NONE;
      endcase
    end

    // Pointer movement after a data access
    if (advance) begin
      unique case (q.amode)
        DRC_AM_PAGE: d.col = q.col + 7'h01;
        DRC_AM_HORIZ: begin
          if (q.col == q.col_end) begin
            d.col = q.col_start;
            d.page = (q.page == q.page_end) ? q.page_start : q.page + 3'h1;
          end else begin
            d.col = q.col + 7'h01;
          end
        end
        DRC_AM_VERT: begin
          if (q.page == q.page_end) begin
            d.page = q.page_start;
            d.col = (q.col == q.col_end) ? q.col_start : q.col + 7'h01;
          end else begin
            d.page = q.page + 3'h1;
          end
        end
        default: ;
      endcase
    end

    // Scan read for the panel side
    d.scan = q.entire_on ? `DRC_ALL_ON : display_ram[scan_addr_i];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.cs_s <= 3'h7;
      q.rw_s <= 3'h7;
      q.e_s <= 3'h7;
      q.sclk_s <= 3'h7;
      q.arg <= DRC_ARG_NONE;
      q.amode <= DRC_AM_PAGE;
      q.col_end <= `DRC_COL_END_RST;
      q.page_end <= `DRC_PAGE_END_RST;
      q.contrast <= `DRC_CONTRAST_RST;
      q.dout_oe_n <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_n_i && ce_i && wr_en) begin
      display_ram[ram_addr] <= byte_v;
    end
  end

  assign link.dd = q.dout;
  assign link.dd_oe_n = q.dout_oe_n;
  assign scan_data_o = q.scan;
  assign start_line_o = q.start_line;
  assign contrast_o = q.contrast;
  assign seg_remap_o = q.remap;
  assign entire_on_o = q.entire_on;
  assign addr_mode_o = q.amode;
  assign col_ptr_o = q.col;
  assign page_ptr_o = q.page;
endmodule

// >>> drc_fifo.sv
`timescale 1ns/1ps
`include "drc_params.svh"

module drc_fifo #(
  parameter int WIDTH = `DRC_FIFO_WIDTH,
  parameter int DEPTH = `DRC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  import drc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ready;
  } drc_fifo_st_t;

  drc_fifo_st_t q, d;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic push;
  logic pop;

  always_comb begin
    d = q;
    push = in_valid_i & q.ready;
    pop = (q.cnt != '0) & out_ready_i;
    if (push) begin
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.ready = d.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.ready <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_n_i && ce_i && push) begin
      mem[q.wp] <= in_data_i;
    end
  end

  assign in_ready_o = q.ready;
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = mem[q.rp];
endmodule

// >>> drc_host.sv
`timescale 1ns/1ps
`include "drc_params.svh"

module drc_host (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic rst_n_i,
  // Link
  drc_if.host link,
  // Requests
  input wire logic [1:0] bus_mode_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_read_i,
  input wire logic req_dc_i,
  input wire logic [7:0] req_data_i,
  // Answers
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic busy_o
);
  import drc_pkg::*;

  drc_host_st_t q, d;
  logic f_valid;
  logic f_ready;
  logic [9:0] f_data;
  logic is_6800;

  // Requests keep their order, so page, low and high column commands arrive as queued
  drc_fifo #(.WIDTH(`DRC_FIFO_WIDTH), .DEPTH(`DRC_FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .ce_i(ce_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i({req_read_i, req_dc_i, req_data_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // A new bus style is taken while idle and settles one cycle before the next pop
  assign f_ready = (q.st == DRC_HS_IDLE) && (q.bus_mode == bus_mode_i);

  always_comb begin
    d = q;
    is_6800 = q.bus_mode == DRC_BUS_6800;
    d.rsp_v = 1'b0;
    d.b_s1 = link.bus_d;
    d.b_s2 = q.b_s1;
    unique case (q.st)
      DRC_HS_IDLE: begin
        d.bus_mode = bus_mode_i;
        d.busy = 1'b0;
        d.cs_n = 1'b1;
        d.hd_oe_n = 1'b1;
        d.rw_wr_n = 1'b1;
        // Strobe idle level follows the incoming style, so a selected device sees no false edge
        d.e_rd_n = bus_mode_i != DRC_BUS_6800;
        d.sclk = 1'b1;
        if (f_valid && f_ready) begin
          // Command bytes pass through unchanged; the caller sends defined codes only
          d.dc = f_data[8];
          d.rd = f_data[9];
          d.hd = f_data[7:0];
          d.sh = f_data[7:0];
          if (q.bus_mode == DRC_BUS_SERIAL) begin
            if (!f_data[9]) begin
              d.busy = 1'b1;
              d.cs_n = 1'b0;
              d.bits = 3'h0;
              d.sclk = 1'b0;
              d.sdin = f_data[7];
              d.cnt = 5'(`DRC_HALF_CYC - 1);
              d.st = DRC_HS_SER_LO;
            end
          end else begin
            d.busy = 1'b1;
            d.cs_n = 1'b0;
            d.hd_oe_n = f_data[9];
            d.rw_wr_n = is_6800 ? f_data[9] : 1'b1;
            d.cnt = 5'(`DRC_SETUP_CYC - 1);
            d.st = DRC_HS_SETUP;
          end
        end
      end
      DRC_HS_SETUP: begin
        d.cnt = q.cnt - 5'h01;
        if (q.cnt == 5'h00) begin
          d.cnt = 5'(`DRC_STROBE_CYC - 1);
          d.st = DRC_HS_STROBE;
          if (is_6800) begin
            d.e_rd_n = 1'b1;
          end else if (q.rd) begin
            d.e_rd_n = 1'b0;
          end else begin
            d.rw_wr_n = 1'b0;
          end
        end
      end
      DRC_HS_STROBE: begin
        d.cnt = q.cnt - 5'h01;
        if (q.cnt == 5'h00) begin
          d.rsp_v = q.rd;
          d.rsp_d = q.b_s2;
          d.e_rd_n = !is_6800;
          d.rw_wr_n = is_6800 ? q.rw_wr_n : 1'b1;
          d.cnt = 5'(`DRC_HOLD_CYC - 1);
          d.st = DRC_HS_HOLD;
        end
      end
      DRC_HS_HOLD: begin
        d.cnt = q.cnt - 5'h01;
        if (q.cnt == 5'h00) begin
          d.cs_n = 1'b1;
          d.hd_oe_n = 1'b1;
          d.rw_wr_n = 1'b1;
          d.st = DRC_HS_IDLE;
        end
      end
      DRC_HS_SER_LO: begin
        d.cnt = q.cnt - 5'h01;
        if (q.cnt == 5'h00) begin
          d.sclk = 1'b1;
          d.cnt = 5'(`DRC_HALF_CYC - 1);
          d.st = DRC_HS_SER_HI;
        end
      end
      DRC_HS_SER_HI: begin
        d.cnt = q.cnt - 5'h01;
        if (q.cnt == 5'h00) begin
          if (q.bits == 3'h7) begin
            d.cnt = 5'(`DRC_HOLD_CYC - 1);
            d.st = DRC_HS_HOLD;
          end else begin
            d.bits = q.bits + 3'h1;
            d.sh = {q.sh[6:0], 1'b0};
            d.sdin = q.sh[6];
            d.sclk = 1'b0;
            d.cnt = 5'(`DRC_HALF_CYC - 1);
            d.st = DRC_HS_SER_LO;
          end
        end
      end
      default: d.st = DRC_HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= DRC_HS_IDLE;
      q.cs_n <= 1'b1;
      q.rw_wr_n <= 1'b1;
      q.sclk <= 1'b1;
      q.hd_oe_n <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign link.bus_mode = q.bus_mode;
  assign link.cs_n = q.cs_n;
  assign link.dc = q.dc;
  assign link.rw_wr_n = q.rw_wr_n;
  assign link.e_rd_n = q.e_rd_n;
  assign link.sclk = q.sclk;
  assign link.sdin = q.sdin;
  assign link.hd = q.hd;
  assign link.hd_oe_n = q.hd_oe_n;
  assign rsp_valid_o = q.rsp_v;
  assign rsp_data_o = q.rsp_d;
  assign busy_o = q.busy;
endmodule

// >>> drc_if.sv
`timescale 1ns/1ps
`include "drc_params.svh"

interface drc_if;
  logic [1:0] bus_mode;
  logic cs_n;
  logic dc;
  logic rw_wr_n;
  logic e_rd_n;
  logic sclk;
  logic sdin;
  logic [7:0] hd;
  logic hd_oe_n;
  logic [7:0] dd;
  logic dd_oe_n;
  logic [7:0] bus_d;

  // Shared data bus level, pulled high when nobody drives
  assign bus_d = !dd_oe_n ? dd : (!hd_oe_n ? hd : `DRC_DATA_IDLE);

  modport dev (
    input bus_mode, cs_n, dc, rw_wr_n, e_rd_n, sclk, sdin, bus_d,
    output dd, dd_oe_n
  );

  modport host (
    output bus_mode, cs_n, dc, rw_wr_n, e_rd_n, sclk, sdin, hd, hd_oe_n,
    input bus_d
  );
endinterface

// >>> drc_params.svh
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// Clock and pin timing
`define DRC_CLK_NS 40
`define DRC_T_SETUP_NS 80
`define DRC_T_STROBE_NS 400
`define DRC_T_HOLD_NS 120
`define DRC_T_SCLK_HALF_NS 160
`define DRC_CYC_MIN(ns) ((((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS) > 0 ? (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS) : 1)
`define DRC_SETUP_CYC `DRC_CYC_MIN(`DRC_T_SETUP_NS)
`define DRC_STROBE_CYC `DRC_CYC_MIN(`DRC_T_STROBE_NS)
`define DRC_HOLD_CYC `DRC_CYC_MIN(`DRC_T_HOLD_NS)
`define DRC_HALF_CYC `DRC_CYC_MIN(`DRC_T_SCLK_HALF_NS)

// Command codes and field positions
`define DRC_CMD_COL_LO 4'h0
`define DRC_CMD_COL_HI 5'h02
`define DRC_CMD_AMODE 8'h20
`define DRC_CMD_COL_RANGE 8'h21
`define DRC_CMD_PAGE_RANGE 8'h22
`define DRC_CMD_START_LINE 2'h1
`define DRC_CMD_CONTRAST 8'h81
`define DRC_CMD_REMAP 7'h50
`define DRC_CMD_ENTIRE_ON 7'h52
`define DRC_CMD_PAGE_SEL 5'h16

// Reset values and fixed bytes
`define DRC_COL_END_RST 7'h7F
`define DRC_PAGE_END_RST 3'h7
`define DRC_CONTRAST_RST 8'h7F
`define DRC_STATUS_BYTE 8'h40
`define DRC_DATA_IDLE 8'hFF
`define DRC_ALL_ON 8'hFF

// Sizes
`define DRC_RAM_WORDS 1024
`define DRC_FIFO_DEPTH 16
`define DRC_FIFO_WIDTH 10

`endif

// >>> drc_pkg.sv
package drc_pkg;

  typedef enum logic [1:0] {
    DRC_BUS_6800 = 2'b00,
    DRC_BUS_8080 = 2'b01,
    DRC_BUS_SERIAL = 2'b10
  } drc_bus_t;

  typedef enum logic [1:0] {
    DRC_AM_HORIZ = 2'b00,
    DRC_AM_VERT = 2'b01,
    DRC_AM_PAGE = 2'b10
  } drc_amode_t;

  typedef enum logic [2:0] {
    DRC_ARG_NONE = 3'b000,
    DRC_ARG_AMODE = 3'b001,
    DRC_ARG_COL_S = 3'b010,
    DRC_ARG_COL_E = 3'b011,
    DRC_ARG_PG_S = 3'b100,
    DRC_ARG_PG_E = 3'b101,
    DRC_ARG_CONTRAST = 3'b110
  } drc_arg_t;

  typedef enum logic [2:0] {
    DRC_HS_IDLE = 3'b000,
    DRC_HS_SETUP = 3'b001,
    DRC_HS_STROBE = 3'b010,
    DRC_HS_HOLD = 3'b011,
    DRC_HS_SER_LO = 3'b100,
    DRC_HS_SER_HI = 3'b101
  } drc_hst_t;

  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [2:0] cs_s;
    logic [2:0] dc_s;
    logic [2:0] rw_s;
    logic [2:0] e_s;
    logic [2:0] sclk_s;
    logic [2:0] sdin_s;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    drc_arg_t arg;
    drc_amode_t amode;
    logic [6:0] col;
    logic [6:0] col_start;
    logic [6:0] col_end;
    logic [2:0] page;
    logic [2:0] page_start;
    logic [2:0] page_end;
    logic [5:0] start_line;
    logic [7:0] contrast;
    logic remap;
    logic entire_on;
    logic [7:0] rd_latch;
    logic [7:0] dout;
    logic dout_oe_n;
    logic [7:0] scan;
  } drc_dev_st_t;

  typedef struct packed {
    drc_hst_t st;
    logic [1:0] bus_mode;
    logic cs_n;
    logic dc;
    logic rw_wr_n;
    logic e_rd_n;
    logic sclk;
    logic sdin;
    logic [7:0] hd;
    logic hd_oe_n;
    logic rd;
    logic [7:0] sh;
    logic [2:0] bits;
    logic [4:0] cnt;
    logic [7:0] b_s1;
    logic [7:0] b_s2;
    logic rsp_v;
    logic [7:0] rsp_d;
    logic busy;
  } drc_host_st_t;

endpackage

// >>> drc_sva.sv
`timescale 1ns/1ps
`include "drc_params.svh"
module drc_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Link
  input wire logic [1:0] bus_mode,
  input wire logic cs_n,
  input wire logic dc,
  input wire logic rw_wr_n,
  input wire logic e_rd_n,
  input wire logic sclk,
  input wire logic [7:0] hd,
  input wire logic hd_oe_n,
  input wire logic [7:0] dd,
  input wire logic dd_oe_n
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SERIAL_NO_DRIVE: assert property ((bus_mode == 2'b10) [*4] |-> dd_oe_n)
    else $error("device drives data in serial mode");
  AST_SCLK_IDLE: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("serial clock not idle high");
  AST_READ_DRIVE: assert property ($fell(dd_oe_n) |-> $past(!cs_n, 3) &&
    $past(bus_mode == 2'b01 ? !e_rd_n : (rw_wr_n && e_rd_n), 3))
    else $error("device drive without read strobe");
  AST_READ_RELEASE: assert property ($rose(dd_oe_n) |-> $past(bus_mode == 2'b01 ? e_rd_n : !e_rd_n, 3))
    else $error("device release not after strobe end");
  AST_NO_CONTENTION: assert property (!dd_oe_n |-> hd_oe_n)
    else $error("both ends drive data");
  AST_WR_8080: assert property ($fell(rw_wr_n) && bus_mode == 2'b01 |-> !cs_n && !hd_oe_n && e_rd_n)
    else $error("8080 write strobe without data drive");
  AST_WR_WIDTH: assert property ($fell(rw_wr_n) && bus_mode == 2'b01 |->
    (!rw_wr_n && $stable(hd) && $stable(dc)) [*8] ##1 !rw_wr_n [*2] ##1 rw_wr_n)
    else $error("write strobe width or data hold wrong");
  AST_WR_6800: assert property ($rose(e_rd_n) && bus_mode == 2'b00 && !rw_wr_n |-> !cs_n && !hd_oe_n)
    else $error("6800 write enable without data drive");
  AST_STATUS: assert property (!cs_n && !dc && !dd_oe_n && $past(!dd_oe_n) |-> dd == `DRC_STATUS_BYTE)
    else $error("status byte wrong");

  COV_READ: cover property ($fell(dd_oe_n));
  COV_WR_8080: cover property ($fell(rw_wr_n) && bus_mode == 2'b01);
  COV_SERIAL: cover property (bus_mode == 2'b10 && $fell(cs_n));
endmodule

// >>> tb_display_ram_access_commands.sv
`timescale 1ns/1ps
module tb_display_ram_access_commands;
  import drc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [1:0] bus_mode_i = 2'b01;
  logic req_valid_i = 1'b0;
  logic req_read_i = 1'b0;
  logic req_dc_i = 1'b0;
  logic [7:0] req_data_i = 8'h00;
  logic [9:0] scan_addr_i = 10'h07F;
  logic req_ready_o, rsp_valid_o, busy_o, seg_remap_o, entire_on_o;
  logic [7:0] rsp_data_o, scan_data_o, contrast_o;
  logic [5:0] start_line_o;
  logic [6:0] col_ptr_o;
  logic [2:0] page_ptr_o;
  drc_amode_t addr_mode_o;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  drc_if drc_if_i ();
  drc_host drc_host_i (.core_clk_i(core_clk_i), .ce_i(ce_i), .rst_n_i(rst_n_i), .link(drc_if_i),
    .bus_mode_i(bus_mode_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_read_i(req_read_i),
    .req_dc_i(req_dc_i), .req_data_i(req_data_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .busy_o(busy_o));
  drc_dev drc_dev_i (.core_clk_i(core_clk_i), .ce_i(ce_i), .rst_n_i(rst_n_i), .link(drc_if_i),
    .scan_addr_i(scan_addr_i), .scan_data_o(scan_data_o), .start_line_o(start_line_o), .contrast_o(contrast_o),
    .seg_remap_o(seg_remap_o), .entire_on_o(entire_on_o), .addr_mode_o(addr_mode_o), .col_ptr_o(col_ptr_o),
    .page_ptr_o(page_ptr_o));
  drc_sva drc_sva_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_mode(drc_if_i.bus_mode),
    .cs_n(drc_if_i.cs_n), .dc(drc_if_i.dc), .rw_wr_n(drc_if_i.rw_wr_n), .e_rd_n(drc_if_i.e_rd_n),
    .sclk(drc_if_i.sclk), .hd(drc_if_i.hd), .hd_oe_n(drc_if_i.hd_oe_n), .dd(drc_if_i.dd),
    .dd_oe_n(drc_if_i.dd_oe_n));

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic push(input logic rd, input logic dcv, input logic [7:0] d);
    req_valid_i <= 1'b1;
    req_read_i <= rd;
    req_dc_i <= dcv;
    req_data_i <= d;
    @(posedge core_clk_i);
    while (req_ready_o !== 1'b1) @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // Idle means no bus cycle for six cycles, so device updates have landed
  task automatic settle();
    int quiet;
    quiet = 0;
    while (quiet < 6) begin
      @(posedge core_clk_i);
      quiet = (busy_o === 1'b0) ? quiet + 1 : 0;
    end
  endtask

  task automatic send(input logic dcv, input logic [7:0] q [$]);
    foreach (q[i]) push(1'b0, dcv, q[i]);
    settle();
  endtask

  task automatic rd(input logic dcv, input logic [7:0] exp, input string what);
    int n;
    push(1'b1, dcv, 8'h00);
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid_o});
    if (what != "") chk(what, exp, rsp_data_o);
    settle();
  endtask

  task automatic test_cmds();
    chk("mode_rst", 8'h02, {6'h00, addr_mode_o});
    chk("busy_rst", 8'h00, {7'h00, busy_o});
    chk("contrast_rst", 8'h7F, contrast_o);
    send(1'b0, '{8'h6A, 8'h81, 8'h33, 8'hB5, 8'h03, 8'h12});
    chk("start_line", 8'h2A, {2'b00, start_line_o});
    chk("contrast", 8'h33, contrast_o);
    chk("page", 8'h05, {5'h00, page_ptr_o});
    chk("col", 8'h23, {1'b0, col_ptr_o});
    for (int i = 0; i < 4; i++) begin
      send(1'b0, '{8'h20, 8'(i)});
      chk("addr_mode", (i < 2) ? 8'(i) : 8'h02, {6'h00, addr_mode_o});
    end
    send(1'b0, '{8'hA1, 8'hB0, 8'h00, 8'h10});
    chk("remap", 8'h01, {7'h00, seg_remap_o});
    send(1'b1, '{8'h5A});
    send(1'b0, '{8'hA0});
    chk("remapped_byte", 8'h5A, scan_data_o);
    send(1'b0, '{8'hA5});
    chk("entire_on", 8'hFF, scan_data_o);
    chk("entire_on_flag", 8'h01, {7'h00, entire_on_o});
    send(1'b0, '{8'hA4});
    chk("entire_off", 8'h5A, scan_data_o);
    chk("entire_off_flag", 8'h00, {7'h00, entire_on_o});
    $display("test cmds done");
  endtask

  task automatic test_page();
    bus_mode_i <= 2'b00;
    send(1'b0, '{8'hB2, 8'h03, 8'h10});
    send(1'b1, '{8'hAA, 8'hBB, 8'hCC});
    chk("col_after_wr", 8'h06, {1'b0, col_ptr_o});
    chk("page_after_wr", 8'h02, {5'h00, page_ptr_o});
    rd(1'b0, 8'h40, "status");
    chk("col_after_status", 8'h06, {1'b0, col_ptr_o});
    bus_mode_i <= 2'b01;
    send(1'b0, '{8'hB2, 8'h03, 8'h10});
    rd(1'b1, 8'h00, "");
    rd(1'b1, 8'hAA, "data0");
    bus_mode_i <= 2'b00;
    rd(1'b1, 8'hBB, "data1");
    chk("col_after_rd", 8'h06, {1'b0, col_ptr_o});
    send(1'b0, '{8'h0F, 8'h17});
    send(1'b1, '{8'h11});
    chk("col_wrap", 8'h00, {1'b0, col_ptr_o});
    chk("page_kept", 8'h02, {5'h00, page_ptr_o});
    $display("test page done");
  endtask

  task automatic test_range(input logic [7:0] m, input logic [1:0] bm);
    int a;
    int b;
    bus_mode_i <= bm;
    send(1'b0, '{8'h20, m, 8'h21, 8'h02, 8'h03, 8'h22, 8'h01, 8'h02});
    chk("col_start", 8'h02, {1'b0, col_ptr_o});
    chk("page_start", 8'h01, {5'h00, page_ptr_o});
    for (int i = 1; i <= 4; i++) begin
      a = i % 2;
      b = (i / 2) % 2;
      send(1'b1, '{8'(8'h30 + i)});
      chk("col_step", 8'(2 + ((m == 8'h00) ? a : b)), {1'b0, col_ptr_o});
      chk("page_step", 8'(1 + ((m == 8'h00) ? b : a)), {5'h00, page_ptr_o});
    end
    $display("test range done");
  endtask

  task automatic test_serial();
    int seen;
    int acc;
    int full;
    bus_mode_i <= 2'b10;
    send(1'b0, '{8'h55});
    chk("serial_cmd", 8'h15, {2'b00, start_line_o});
    push(1'b1, 1'b1, 8'h00);
    seen = 0;
    repeat (100) begin
      @(posedge core_clk_i);
      if (rsp_valid_o === 1'b1) seen++;
    end
    chk("serial_rsp", 8'h00, 8'(seen));
    acc = 0;
    full = 0;
    req_read_i <= 1'b0;
    req_dc_i <= 1'b0;
    req_data_i <= 8'h40;
    req_valid_i <= 1'b1;
    while (acc < 20) begin
      @(posedge core_clk_i);
      if (req_ready_o === 1'b1) begin
        acc++;
        req_data_i <= 8'(8'h40 + acc);
      end else begin
        full++;
      end
    end
    req_valid_i <= 1'b0;
    settle();
    chk("fifo_refused", 8'h01, {7'h00, full > 0});
    chk("fifo_last", 8'h13, {2'b00, start_line_o});
    $display("test serial done");
  endtask

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    test_cmds();
    test_page();
    test_range(8'h00, 2'b01);
    test_range(8'h01, 2'b10);
    test_serial();
    results();
  end
endmodule
